// File: logic/uspl_pkg.sv
/*
  Constants shared by the serial and modem pin logic: register offsets,
  field positions, reset values and timing counts.
  Assumes a 32-bit AHB-Lite register bus and a 200 MHz core clock.
*/
package uspl_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_ENH_FEAT  = 8'h00;
  localparam logic [7:0] OFS_MODEM_CTL = 8'h04;
  localparam logic [7:0] OFS_FEAT_CTL  = 8'h08;
  localparam logic [7:0] OFS_INT_EN    = 8'h0C;
  localparam logic [7:0] OFS_TX_DATA   = 8'h10;
  localparam logic [7:0] OFS_RX_DATA   = 8'h14;
  localparam logic [7:0] OFS_INT_STAT  = 8'h18;
  localparam logic [7:0] OFS_LINE_STAT = 8'h1C;
  localparam logic [7:0] OFS_DIVISOR   = 8'h20;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int EF_RS485    = 4;
  localparam int EF_AUTO_RTS = 6;
  localparam int EF_AUTO_CTS = 7;
  localparam int MC_DTR      = 0;
  localparam int MC_RTS      = 1;
  localparam int MC_GPO1     = 2;
  localparam int MC_INFRARED = 6;
  localparam int FC_RS485    = 3;
  localparam int IS_TX_DONE  = 0;
  localparam int IS_RX_BYTE  = 1;
  localparam int IS_RX_ERR   = 2;
  localparam int IS_MODEM    = 3;
  localparam int IS_RTS      = 6;
  localparam int IS_CTS      = 7;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0]  RST_CFG8    = 8'h00;
  localparam logic [15:0] RST_DIVISOR = 16'h0001;

  // ----------------------------------------
  // Timing counts and PC decode
  // ----------------------------------------
  localparam logic [3:0] OVS_LAST    = 4'hF;
  localparam logic [3:0] OVS_MID     = 4'h7;
  localparam logic [3:0] IR_PULSE    = 4'h3;
  localparam logic [3:0] LAST_BIT    = 4'h7;
  localparam logic [6:0] BASE_COM_A  = 7'h7F;
  localparam logic [6:0] BASE_COM_B  = 7'h5F;
  localparam logic [6:0] BASE_COM_C  = 7'h7D;
  localparam logic [6:0] BASE_PRN2   = 7'h4F;
  localparam logic [2:0] IRQ_LINE_A  = 3'b001;
  localparam logic [2:0] IRQ_LINE_B  = 3'b010;
  localparam logic [2:0] IRQ_LINE_C  = 3'b100;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uspl_rx_st_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} uspl_tx_st_t;
endpackage

// File: logic/uspl_tx_shift.sv
/*
  Transmit shifter: start bit, eight data bits LSB first, one stop bit,
  sixteen oversample ticks per bit, with infrared pulse encoding.
  Assumes tick is a one-cycle pulse at sixteen times the bit rate.
*/
`timescale 1ns/100ps
module uspl_tx_shift (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic [7:0] data,
  input  wire logic       ir_mode,
  output logic            tx_pin,
  output logic            busy,
  output logic            done
);
  uspl_pkg::uspl_tx_st_t st_ff;
  logic [3:0]            ovs_ff;
  logic [3:0]            bit_ff;
  logic [7:0]            shf_ff;
  logic                  bitval;

  always_comb begin
    unique case (st_ff)
      uspl_pkg::TX_IDLE:  bitval = 1'b1;
      uspl_pkg::TX_START: bitval = 1'b0;
      uspl_pkg::TX_DATA:  bitval = shf_ff[0];
      uspl_pkg::TX_STOP:  bitval = 1'b1;
    endcase
  end

  // ----------------------------------------
  // Character sequencing
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff  <= uspl_pkg::TX_IDLE;
      ovs_ff <= 4'h0;
      bit_ff <= 4'h0;
      shf_ff <= 8'h00;
      done   <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (st_ff == uspl_pkg::TX_IDLE) begin
        if (start) begin
          st_ff  <= uspl_pkg::TX_START;
          shf_ff <= data;
          ovs_ff <= 4'h0;
        end
      end else if (tick) begin
        ovs_ff <= ovs_ff + 4'h1;
        if (ovs_ff == uspl_pkg::OVS_LAST) begin
          unique case (st_ff)
            uspl_pkg::TX_START: begin
              st_ff  <= uspl_pkg::TX_DATA;
              bit_ff <= 4'h0;
            end
            uspl_pkg::TX_DATA: begin
              shf_ff <= {1'b0, shf_ff[7:1]};
              bit_ff <= bit_ff + 4'h1;
              if (bit_ff == uspl_pkg::LAST_BIT) begin
                st_ff <= uspl_pkg::TX_STOP;
              end
            end
            default: begin
              st_ff <= uspl_pkg::TX_IDLE;
              done  <= 1'b1;
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Pin polarity
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_pin <= 1'b1;
      busy   <= 1'b0;
    end else if (ce) begin
      busy <= (st_ff != uspl_pkg::TX_IDLE) || start;
      if (ir_mode) begin
        tx_pin <= !bitval && (ovs_ff < uspl_pkg::IR_PULSE);
      end else begin
        tx_pin <= bitval;
      end
    end
  end
endmodule

// File: logic/uspl_pins.sv
/*
  Serial and modem pin logic of a UART with an AHB-Lite register port:
  data polarity, infrared mode, auto flow control, modem lines as GPIO,
  RS-485 direction, PC address decode and configuration reset.
  Assumes all pin inputs are synchronous to core_clk.
*/
`timescale 1ns/100ps
// How it works
// - TX idles high normal, low infrared
// - Infrared from strap pin or software bit
// - RX idle 1 normal, 0 infrared decoded
// - Auto RTS only once RTS bit set
// - Auto CTS pauses transmitter between characters
// - DTR output usable as general output
// - DSR, CD, RI readable as general inputs
// - Bus mode low enables COM decode
// - Printer decode low, else driver disable
// - Port pin direction or general output
// - Direction pin low throughout transmission
// - Config reset input clears configuration registers
// - Direction needs both enable bits set
// - Receive after stop bit, transmit on load
// - Direction high receive, low transmit
module uspl_pins #(
  parameter int DIV_W = 16
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        config_reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic             irq,
  input  wire logic        rx_pin,
  output logic             tx_pin,
  output logic             rts_n,
  input  wire logic        cts_n,
  output logic             dtr_n,
  input  wire logic        dsr_n,
  input  wire logic        cd_n,
  input  wire logic        ri_n,
  output logic             output_port1_direction,
  input  wire logic        infrared_enable_pin,
  input  wire logic        bus_mode_sel_n,
  input  wire logic        addr_enable_n,
  input  wire logic [2:0]  port_select,
  input  wire logic [6:0]  pc_addr,
  output logic             com_select,
  output logic [2:0]       irq_route,
  output logic             printer_port2_decode_n
);
  logic [7:0]        enh_ff, mctl_ff, fctl_ff, ien_ff, stat_ff;
  logic [DIV_W-1:0]  div_ff, bcnt_ff;
  logic              tick_ff, strap_ff, strap_done_ff;
  logic              ph_ff, ph_wr_ff, rd_phase_ff;
  logic [7:0]        ph_addr_ff;
  logic [7:0]        thr_ff, rbuf_ff, rshf_ff;
  logic              thr_full_ff, start_ff, tx_active_ff, rx_full_ff, rx_err_ff;
  logic              tx_busy, tx_done, tx_raw;
  logic [3:0]        modem_ff;
  logic              rts_int;
  logic [7:0]        nxt_stat;
  logic [31:0]       rd_mux;
  uspl_pkg::uspl_rx_st_t rx_st_ff;
  logic [3:0]        rovs_ff, rbit_ff;
  logic              rmid_ff, rseen_ff;
  logic              ir_mode, rx_act, rx_bitval, rx_evt, err_evt, dir_en;
  logic              wr_txd, rd_rxd, rd_stat, acc;
  logic [6:0]        com_base;
  logic [2:0]        com_irq;
  logic              com_ok;

  // ----------------------------------------
  // AHB-Lite slave, one wait state
  // ----------------------------------------
  assign acc    = hsel && hready && htrans[1];
  assign wr_txd = ph_ff && ph_wr_ff && (ph_addr_ff == uspl_pkg::OFS_TX_DATA);
  assign rd_rxd = ph_ff && !ph_wr_ff && (ph_addr_ff == uspl_pkg::OFS_RX_DATA);
  assign rd_stat = ph_ff && !ph_wr_ff && (ph_addr_ff == uspl_pkg::OFS_INT_STAT);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_ff      <= 1'b0;
      ph_wr_ff   <= 1'b0;
      ph_addr_ff <= 8'h00;
      hreadyout  <= 1'b1;
      hrdata     <= 32'h0000_0000;
      hresp      <= 1'b0;
    end else if (ce) begin
      ph_ff     <= acc;
      hreadyout <= !acc;
      if (acc) begin
        ph_wr_ff   <= hwrite;
        ph_addr_ff <= {haddr[7:2], 2'b00};
      end
      if (ph_ff && !ph_wr_ff) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (ph_addr_ff)
      uspl_pkg::OFS_ENH_FEAT:  rd_mux[7:0] = enh_ff;
      uspl_pkg::OFS_MODEM_CTL: rd_mux[7:0] = mctl_ff;
      uspl_pkg::OFS_FEAT_CTL:  rd_mux[7:0] = fctl_ff;
      uspl_pkg::OFS_INT_EN:    rd_mux[7:0] = ien_ff;
      uspl_pkg::OFS_TX_DATA:   rd_mux[7:0] = thr_ff;
      uspl_pkg::OFS_RX_DATA:   rd_mux[7:0] = rbuf_ff;
      uspl_pkg::OFS_INT_STAT:  rd_mux[7:0] = stat_ff;
      uspl_pkg::OFS_LINE_STAT: rd_mux[9:0] = {!bus_mode_sel_n, ir_mode, ~cts_n, ~ri_n,
                                              ~cd_n, ~dsr_n, tx_busy, thr_full_ff,
                                              rx_err_ff, rx_full_ff};
      uspl_pkg::OFS_DIVISOR:   rd_mux[DIV_W-1:0] = div_ff;
      default:                 rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      enh_ff  <= uspl_pkg::RST_CFG8;
      mctl_ff <= uspl_pkg::RST_CFG8;
      fctl_ff <= uspl_pkg::RST_CFG8;
      ien_ff  <= uspl_pkg::RST_CFG8;
      div_ff  <= DIV_W'(uspl_pkg::RST_DIVISOR);
    end else if (ce) begin
      if (config_reset) begin
        enh_ff  <= uspl_pkg::RST_CFG8;
        mctl_ff <= uspl_pkg::RST_CFG8;
        fctl_ff <= uspl_pkg::RST_CFG8;
        ien_ff  <= uspl_pkg::RST_CFG8;
        div_ff  <= DIV_W'(uspl_pkg::RST_DIVISOR);
      end else if (ph_ff && ph_wr_ff) begin
        unique case (ph_addr_ff)
          uspl_pkg::OFS_ENH_FEAT:  enh_ff  <= hwdata[7:0];
          uspl_pkg::OFS_MODEM_CTL: mctl_ff <= hwdata[7:0];
          uspl_pkg::OFS_FEAT_CTL:  fctl_ff <= hwdata[7:0];
          uspl_pkg::OFS_INT_EN:    ien_ff  <= hwdata[7:0];
          uspl_pkg::OFS_DIVISOR:   div_ff  <= hwdata[DIV_W-1:0];
          default:                 div_ff  <= div_ff;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Infrared strap and baud tick
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_ff      <= 1'b0;
      strap_done_ff <= 1'b0;
      bcnt_ff       <= '0;
      tick_ff       <= 1'b0;
    end else if (ce) begin
      if (!strap_done_ff) begin
        strap_ff      <= infrared_enable_pin;
        strap_done_ff <= 1'b1;
      end
      tick_ff <= (bcnt_ff == '0);
      bcnt_ff <= (bcnt_ff == '0) ? div_ff - DIV_W'(1) : bcnt_ff - DIV_W'(1);
    end
  end

  assign ir_mode = strap_ff || mctl_ff[uspl_pkg::MC_INFRARED];

  // ----------------------------------------
  // Transmit holding and flow control
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      thr_ff       <= 8'h00;
      thr_full_ff  <= 1'b0;
      start_ff     <= 1'b0;
      tx_active_ff <= 1'b0;
    end else if (ce) begin
      start_ff <= thr_full_ff && !tx_busy && !start_ff &&
                  !(enh_ff[uspl_pkg::EF_AUTO_CTS] && cts_n);
      if (wr_txd) begin
        thr_ff      <= hwdata[7:0];
        thr_full_ff <= 1'b1;
      end else if (start_ff) begin
        thr_full_ff <= 1'b0;
      end
      // load enters transmit, stop bit ends it
      if (wr_txd) begin
        tx_active_ff <= 1'b1;
      end else if (tx_done && !thr_full_ff && !start_ff) begin
        tx_active_ff <= 1'b0;
      end
    end
  end

  uspl_tx_shift u_tx (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .tick     (tick_ff),
    .start    (start_ff),
    .data     (thr_ff),
    .ir_mode  (ir_mode),
    .tx_pin   (tx_raw),
    .busy     (tx_busy),
    .done     (tx_done)
  );

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  // idle level follows mode
  assign rx_act    = ir_mode ? rx_pin : !rx_pin;
  assign rx_bitval = ir_mode ? !(rseen_ff || rx_act) : rmid_ff;
  assign rx_evt    = ce && tick_ff && (rx_st_ff == uspl_pkg::RX_STOP) &&
                     (rovs_ff == uspl_pkg::OVS_LAST);
  assign err_evt   = rx_evt && !rx_bitval;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_ff <= uspl_pkg::RX_IDLE;
      rovs_ff  <= 4'h0;
      rbit_ff  <= 4'h0;
      rmid_ff  <= 1'b1;
      rseen_ff <= 1'b0;
      rshf_ff  <= 8'h00;
    end else if (ce && tick_ff) begin
      rovs_ff  <= rovs_ff + 4'h1;
      rseen_ff <= (rovs_ff == uspl_pkg::OVS_LAST) ? 1'b0 : (rseen_ff || rx_act);
      if (rovs_ff == uspl_pkg::OVS_MID) begin
        rmid_ff <= rx_pin;
      end
      unique case (rx_st_ff)
        uspl_pkg::RX_IDLE: begin
          rovs_ff <= 4'h1;
          if (rx_act) begin
            rx_st_ff <= uspl_pkg::RX_START;
          end
        end
        uspl_pkg::RX_START: begin
          if (rovs_ff == uspl_pkg::OVS_LAST) begin
            rx_st_ff <= uspl_pkg::RX_DATA;
            rbit_ff  <= 4'h0;
          end
        end
        uspl_pkg::RX_DATA: begin
          if (rovs_ff == uspl_pkg::OVS_LAST) begin
            rshf_ff <= {rx_bitval, rshf_ff[7:1]};
            rbit_ff <= rbit_ff + 4'h1;
            if (rbit_ff == uspl_pkg::LAST_BIT) begin
              rx_st_ff <= uspl_pkg::RX_STOP;
            end
          end
        end
        uspl_pkg::RX_STOP: begin
          if (rovs_ff == uspl_pkg::OVS_LAST) begin
            rx_st_ff <= uspl_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rbuf_ff    <= 8'h00;
      rx_full_ff <= 1'b0;
      rx_err_ff  <= 1'b0;
    end else if (ce) begin
      if (rx_evt) begin
        rbuf_ff    <= rshf_ff;
        rx_full_ff <= 1'b1;
        rx_err_ff  <= err_evt;
      end else if (rd_rxd) begin
        rx_full_ff <= 1'b0;
        rx_err_ff  <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Modem lines and interrupt status
  // ----------------------------------------
  // auto RTS needs RTS bit first
  assign rts_int = !(mctl_ff[uspl_pkg::MC_RTS] &&
                     !(enh_ff[uspl_pkg::EF_AUTO_RTS] && rx_full_ff));

  always_comb begin
    nxt_stat = rd_stat ? 8'h00 : stat_ff;
    nxt_stat[uspl_pkg::IS_TX_DONE] = nxt_stat[uspl_pkg::IS_TX_DONE] || tx_done;
    nxt_stat[uspl_pkg::IS_RX_BYTE] = nxt_stat[uspl_pkg::IS_RX_BYTE] || rx_evt;
    nxt_stat[uspl_pkg::IS_RX_ERR]  = nxt_stat[uspl_pkg::IS_RX_ERR] || err_evt;
    nxt_stat[uspl_pkg::IS_MODEM]   = nxt_stat[uspl_pkg::IS_MODEM] ||
                                     (modem_ff[2:0] != {dsr_n, cd_n, ri_n});
    nxt_stat[uspl_pkg::IS_RTS]     = nxt_stat[uspl_pkg::IS_RTS] || (rts_n != rts_int);
    nxt_stat[uspl_pkg::IS_CTS]     = nxt_stat[uspl_pkg::IS_CTS] || (modem_ff[3] != cts_n);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_ff  <= 8'h00;
      modem_ff <= 4'hF;
      irq      <= 1'b0;
      rts_n    <= 1'b1;
      dtr_n    <= 1'b1;
      tx_pin   <= 1'b1;
    end else if (ce) begin
      stat_ff  <= nxt_stat;
      modem_ff <= {cts_n, dsr_n, cd_n, ri_n};
      irq      <= |(nxt_stat & ien_ff);
      rts_n    <= rts_int;
      dtr_n    <= !mctl_ff[uspl_pkg::MC_DTR];
      tx_pin   <= tx_raw;
    end
  end

  // ----------------------------------------
  // RS-485 direction and PC decode
  // ----------------------------------------
  // both enables required
  assign dir_en = enh_ff[uspl_pkg::EF_RS485] && fctl_ff[uspl_pkg::FC_RS485];

  always_comb begin
    unique case (port_select)
      3'b000:  begin com_base = uspl_pkg::BASE_COM_A; com_irq = uspl_pkg::IRQ_LINE_B; com_ok = 1'b1; end
      3'b001:  begin com_base = uspl_pkg::BASE_COM_B; com_irq = uspl_pkg::IRQ_LINE_C; com_ok = 1'b1; end
      3'b010:  begin com_base = uspl_pkg::BASE_COM_C; com_irq = uspl_pkg::IRQ_LINE_B; com_ok = 1'b1; end
      3'b011:  begin com_base = uspl_pkg::BASE_COM_A; com_irq = uspl_pkg::IRQ_LINE_B; com_ok = 1'b1; end
      3'b100:  begin com_base = uspl_pkg::BASE_COM_B; com_irq = uspl_pkg::IRQ_LINE_A; com_ok = 1'b1; end
      3'b101:  begin com_base = uspl_pkg::BASE_COM_C; com_irq = uspl_pkg::IRQ_LINE_A; com_ok = 1'b1; end
      default: begin com_base = uspl_pkg::BASE_COM_A; com_irq = 3'b000; com_ok = 1'b0; end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      output_port1_direction <= 1'b1;
      com_select             <= 1'b0;
      irq_route              <= 3'b000;
      printer_port2_decode_n <= 1'b1;
      rd_phase_ff            <= 1'b0;
    end else if (ce) begin
      rd_phase_ff <= acc && !hwrite;
      if (dir_en) begin
        output_port1_direction <= !tx_active_ff;
      end else begin
        output_port1_direction <= !mctl_ff[uspl_pkg::MC_GPO1];
      end
      com_select <= !bus_mode_sel_n && com_ok && !addr_enable_n && (pc_addr == com_base);
      irq_route  <= bus_mode_sel_n ? uspl_pkg::IRQ_LINE_A : (irq ? com_irq : 3'b000);
      if (!bus_mode_sel_n) begin
        printer_port2_decode_n <= !(!addr_enable_n && (pc_addr == uspl_pkg::BASE_PRN2));
      end else begin
        printer_port2_decode_n <= !rd_phase_ff;
      end
    end
  end
endmodule

// File: verification/uspl_pins_props.sv
/*
  Checker for the serial and modem pin logic, bound to uspl_pins.
  Assumes ce is held high and all pin inputs follow core_clk.
*/
`timescale 1ns/100ps
module uspl_pins_props (
  input logic       core_clk,
  input logic       rst_b,
  input logic       config_reset,
  input logic       hsel,
  input logic [1:0] htrans,
  input logic       hready,
  input logic       hwrite,
  input logic       hreadyout,
  input logic       hresp,
  input logic       dtr_n,
  input logic       rts_n,
  input logic       output_port1_direction,
  input logic       bus_mode_sel_n,
  input logic       addr_enable_n,
  input logic [2:0] port_select,
  input logic [6:0] pc_addr,
  input logic       com_select,
  input logic [2:0] irq_route,
  input logic       printer_port2_decode_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // Cycles spent in transmit state
  // ----------------------------------------
  logic [7:0] low_cnt_ff;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_ff <= 8'h00;
    end else if (output_port1_direction) begin
      low_cnt_ff <= 8'h00;
    end else if (low_cnt_ff != 8'hFF) begin
      low_cnt_ff <= low_cnt_ff + 8'h01;
    end
  end
  sequence bus_req_s;
    hsel && hready && htrans[1];
  endsequence
  sequence wait_s;
    !hreadyout ##1 hreadyout && !hresp;
  endsequence
  sequence pc_on_s;
    !bus_mode_sel_n && !addr_enable_n;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_BUS_WAIT: assert property (bus_req_s |=> wait_s)
    else $error("bus data phase wrong");
  AST_PC_COM: assert property (
    pc_on_s ##0 (port_select == 3'b000 && pc_addr == 7'h7F) |=> com_select)
    else $error("port decode missing");
  AST_GEN_NO_COM: assert property (bus_mode_sel_n |=> !com_select)
    else $error("decode active in generic mode");
  AST_GEN_IRQ: assert property (bus_mode_sel_n |=> irq_route == 3'b001)
    else $error("generic interrupt route wrong");
  AST_PRINTER_PORT2_DECODE_N_LOW: assert property (
    pc_on_s ##0 (pc_addr == uspl_pkg::BASE_PRN2) |=> !printer_port2_decode_n)
    else $error("printer decode missing");
  AST_DRV_DISABLE: assert property (
    bus_req_s ##0 !hwrite ##1 bus_mode_sel_n |=> !printer_port2_decode_n)
    else $error("driver disable missing on read");
  AST_PRINTER_PORT2_DECODE_N_IDLE: assert property (
    !bus_mode_sel_n && addr_enable_n |=> printer_port2_decode_n)
    else $error("printer decode without enable");
  AST_CFG_RESET: assert property (
    config_reset [*2] |=> dtr_n && rts_n && output_port1_direction)
    else $error("config reset left outputs set");
  AST_DIR_HOLD: assert property (
    $rose(output_port1_direction) |-> low_cnt_ff >= 8'd100)
    else $error("transmit state ended early");
endmodule

bind uspl_pins uspl_pins_props uspl_pins_props_i (.core_clk, .rst_b, .config_reset, .hsel,
  .htrans, .hready, .hwrite, .hreadyout, .hresp, .dtr_n, .rts_n, .output_port1_direction,
  .bus_mode_sel_n, .addr_enable_n, .port_select, .pc_addr, .com_select, .irq_route,
  .printer_port2_decode_n);

// File: verification/uspl_line_model.sv
/*
  Line side model: transceiver and modem driving rx, clear-to-send
  and the modem status inputs. Assumes commands change after a clock edge.
*/
`timescale 1ns/100ps
module uspl_line_model (
  input  logic       core_clk,
  input  logic       ir_mode,
  input  logic       cts_hold,
  input  logic [2:0] modem_act,
  output logic       rx_pin,
  output logic       cts_n,
  output logic       dsr_n,
  output logic       cd_n,
  output logic       ri_n
);
  initial begin
    rx_pin = 1'b1;
    cts_n = 1'b0;
    {ri_n, cd_n, dsr_n} = 3'b111;
  end
  always @(posedge core_clk) begin
    rx_pin <= ~ir_mode;
    cts_n <= cts_hold;
    {ri_n, cd_n, dsr_n} <= ~modem_act;
  end
endmodule

// File: verification/uspl_pins_tb.sv
/*
  Self-checking bench for uspl_pins: register bus tasks and pin checks.
  Assumes the line model drives the serial and modem inputs.
*/
`timescale 1ns/100ps
module uspl_pins_tb;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        config_reset = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, rd;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic        hreadyout, hresp, irq, rx_pin, tx_pin, rts_n, cts_n, dtr_n;
  logic        dsr_n, cd_n, ri_n, output_port1_direction, com_select, printer_port2_decode_n;
  logic        infrared_enable_pin = 1'b0;
  logic        bus_mode_sel_n = 1'b1;
  logic        addr_enable_n = 1'b1;
  logic [2:0]  port_select = 3'b000;
  logic [6:0]  pc_addr = 7'h00;
  logic [2:0]  irq_route;
  logic        ir_line = 1'b0;
  logic        cts_hold = 1'b0;
  logic [2:0]  modem_act = 3'b000;
  int          mismatches = 0;
  int          n_tests = 0;

  always #2.5 core_clk = ~core_clk;

  uspl_pins uspl_pins_i (.core_clk, .rst_b, .ce(1'b1), .config_reset, .hsel(1'b1), .haddr,
    .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
    .hresp, .irq, .rx_pin, .tx_pin, .rts_n, .cts_n, .dtr_n, .dsr_n, .cd_n, .ri_n,
    .output_port1_direction, .infrared_enable_pin, .bus_mode_sel_n, .addr_enable_n,
    .port_select, .pc_addr, .com_select, .irq_route, .printer_port2_decode_n);
  uspl_line_model uspl_line_model_i (.core_clk, .ir_mode(ir_line), .cts_hold, .modem_act,
    .rx_pin, .cts_n, .dsr_n, .cd_n, .ri_n);

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic give_verdict;
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd & m, exp);
  endtask
  task automatic send(input logic [7:0] d, input logic dir);
    int i;
    bus(1'b1, uspl_pkg::OFS_TX_DATA, {24'h00_0000, d});
    for (i = 0; i < 50 && tx_pin !== 1'b0; i++) cyc(1);
    cyc(8);
    chk({tx_pin, output_port1_direction}, {1'b0, dir});
    for (i = 0; i < 8; i++) begin
      cyc(16);
      chk(tx_pin, d[i]);
    end
    cyc(16);
    chk({tx_pin, output_port1_direction}, {1'b1, dir});
    cyc(8);
    for (i = 0; i < 40 && output_port1_direction !== 1'b1; i++) cyc(1);
    chk(output_port1_direction, 1'b1);
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    cyc(20000);
    mismatches++;
    give_verdict;
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    cyc(10);
    rst_b <= 1'b1;
    cyc(2);
    rdm(uspl_pkg::OFS_MODEM_CTL, 32'hFFFF_FFFF, 32'h0000_0000);
    rdm(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000);
    chk({tx_pin, dtr_n, rts_n, output_port1_direction}, 32'h0000_000F);
    bus(1'b1, uspl_pkg::OFS_MODEM_CTL, 32'h0000_0007);
    cyc(2);
    chk({dtr_n, rts_n, output_port1_direction}, 32'h0000_0000);
    cyc(110);
    bus(1'b1, uspl_pkg::OFS_MODEM_CTL, 32'h0000_0000);
    cyc(2);
    chk({dtr_n, rts_n, output_port1_direction}, 32'h0000_0007);
    modem_act <= 3'b101;
    cyc(4);
    rdm(uspl_pkg::OFS_LINE_STAT, 32'h0000_0073, 32'h0000_0050);
    modem_act <= 3'b010;
    cyc(4);
    rdm(uspl_pkg::OFS_LINE_STAT, 32'h0000_0070, 32'h0000_0020);
    bus(1'b1, uspl_pkg::OFS_FEAT_CTL, 32'h0000_0008);
    send(8'hA5, 1'b1);
    bus(1'b1, uspl_pkg::OFS_ENH_FEAT, 32'h0000_0010);
    send(8'h3C, 1'b0);
    bus(1'b1, uspl_pkg::OFS_INT_EN, 32'h0000_0001);
    cyc(2);
    chk(irq, 1'b1);
    rdm(uspl_pkg::OFS_INT_STAT, 32'h0000_0009, 32'h0000_0009);
    cyc(2);
    chk(irq, 1'b0);
    modem_act <= 3'b011;
    cyc(4);
    chk(irq, 1'b0);
    bus(1'b1, uspl_pkg::OFS_INT_EN, 32'h0000_0008);
    cyc(2);
    chk(irq, 1'b1);
    bus(1'b1, uspl_pkg::OFS_INT_EN, 32'h0000_0000);
    bus(1'b1, uspl_pkg::OFS_ENH_FEAT, 32'h0000_0080);
    cts_hold <= 1'b1;
    cyc(4);
    bus(1'b1, uspl_pkg::OFS_TX_DATA, 32'h0000_000F);
    cyc(40);
    chk(tx_pin, 1'b1);
    cts_hold <= 1'b0;
    for (int i = 0; i < 20 && tx_pin !== 1'b0; i++) cyc(1);
    chk(tx_pin, 1'b0);
    cyc(200);
    fork
      bus(1'b1, uspl_pkg::OFS_MODEM_CTL, 32'h0000_0040);
      begin
        cyc(1);
        ir_line <= 1'b1;
      end
    join
    cyc(200);
    chk(tx_pin, 1'b0);
    rdm(uspl_pkg::OFS_RX_DATA, 32'h0000_00FF, 32'h0000_0000);
    cyc(4);
    rdm(uspl_pkg::OFS_LINE_STAT, 32'h0000_0103, 32'h0000_0100);
    bus_mode_sel_n <= 1'b0;
    addr_enable_n <= 1'b0;
    pc_addr <= 7'h7F;
    cyc(3);
    chk({com_select, printer_port2_decode_n}, 32'h0000_0003);
    pc_addr <= 7'h4F;
    cyc(3);
    chk({com_select, printer_port2_decode_n}, 32'h0000_0000);
    addr_enable_n <= 1'b1;
    bus_mode_sel_n <= 1'b1;
    cyc(3);
    chk({com_select, irq_route}, 32'h0000_0001);
    fork
      bus(1'b1, uspl_pkg::OFS_MODEM_CTL, 32'h0000_0003);
      begin
        cyc(1);
        ir_line <= 1'b0;
      end
    join
    config_reset <= 1'b1;
    cyc(3);
    config_reset <= 1'b0;
    cyc(2);
    chk({dtr_n, rts_n}, 32'h0000_0003);
    rdm(uspl_pkg::OFS_MODEM_CTL, 32'hFFFF_FFFF, 32'h0000_0000);
    rst_b <= 1'b0;
    infrared_enable_pin <= 1'b1;
    ir_line <= 1'b1;
    cyc(3);
    rst_b <= 1'b1;
    cyc(4);
    chk(tx_pin, 1'b0);
    rdm(uspl_pkg::OFS_LINE_STAT, 32'h0000_0100, 32'h0000_0100);
    give_verdict;
  end
endmodule
